// [design/phymii_top.sv]
// How it works
// - Transmit clock runs freely at 2.5 or 5 MHz per speed.
// - Each transmit clock with enable high takes the nibble for the line.
// - Idle nibble is zero; other nibbles with enable low are ignored.
// - Separate four-bit transmit and receive paths, one nibble per clock.
// - At 10 Mb/s receive clock follows line only with carrier and link.
// - At 100 Mb/s receive clock follows line while link up, else local.
// - Receive clock runs at 2.5 or 5 MHz per speed.
// - At 10 Mb/s data valid rises with delimiter nibble until frame end.
// - At 100 Mb/s data valid spans first preamble nibble to last nibble.
// - Receive outputs change only on receive clock, one nibble per clock.
// - Line faults in a frame raise receive error for its nibble.
// - At 10 Mb/s carrier sense rises on preamble, falls on end marker.
// - At 100 Mb/s carrier sense rises on J/K, falls on T/R.
// - At 100 Mb/s idle without T/R also drops carrier sense.
// - Half duplex raises collision when transmit and receive both active.
// - Strap address zero holds mii_oe low; the other outputs are not gated by it.
module phymii_top
   import phymii_pkg::*;
#(
   parameter int unsigned HALF_FAST_CYC = HALF_FAST,
   parameter int unsigned HALF_SLOW_CYC = HALF_SLOW
) (
   input  wire logic              clock,
   input  wire logic              reset_n,
   input  wire logic              speed_100,
   input  wire logic              link_up,
   input  wire logic              full_duplex,
   input  wire logic [ADDR_W-1:0] phy_addr,
   input  wire logic              line_carrier,
   input  wire logic              line_clk_tick,
   input  wire logic              line_sym_valid,
   input  wire phymii_sym_s       line_sym,
   output logic                   line_sym_ready,
   output phymii_tx_s             tx_out,
   output logic                   tx_active,
   output logic                   tx_clk,
   input  wire logic              tx_en,
   input  wire logic [NIB_W-1:0]  txd,
   output logic                   rx_clk,
   output logic                   rx_dv,
   output logic [NIB_W-1:0]       rxd,
   output logic                   rx_er,
   output logic                   crs,
   output logic                   col,
   output logic                   mii_oe
);

   // ****************************************
   // Reset release and strap capture
   // ****************************************
   logic              rst_meta;
   logic              rst_n;
   logic              strap_done;
   logic [ADDR_W-1:0] strap_addr;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Strap is caught once after release, never through the reset path
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         strap_done <= 1'b0;
         strap_addr <= '0;
         mii_oe     <= 1'b0;
      end else if (!strap_done) begin
         strap_done <= 1'b1;
         strap_addr <= phy_addr;
         mii_oe     <= phy_addr != ADDR_OFF;
      end
   end

   // ****************************************
   // Speed, held steady during frames
   // ****************************************
   logic speed_cur;
   wire logic quiet = !tx_active && !crs && !rx_dv;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         speed_cur <= 1'b0;
      end else if (quiet) begin
         speed_cur <= speed_100;
      end
   end

   // ****************************************
   // Local divider, shared by both clocks
   // ****************************************
   logic [DIV_W-1:0] div_cnt;
   wire logic [DIV_W-1:0] half_cyc = speed_cur ? DIV_W'(HALF_FAST_CYC) : DIV_W'(HALF_SLOW_CYC);
   wire logic local_tick = (div_cnt >= half_cyc - 1'b1);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= local_tick ? '0 : div_cnt + 1'b1;
      end
   end

   // ****************************************
   // Transmit side
   // ****************************************
   wire logic tx_rise = local_tick && !tx_clk;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_clk    <= 1'b0;
         tx_out    <= '0;
         tx_active <= 1'b0;
      end else begin
         tx_clk       <= local_tick ? !tx_clk : tx_clk;
         tx_out.valid <= tx_rise;
         if (tx_rise) begin
            tx_active     <= tx_en;
            tx_out.en     <= tx_en;
            tx_out.nibble <= tx_en ? txd : NIB_IDLE;
         end
      end
   end

   // ****************************************
   // Receive clock source
   // ****************************************
   wire logic use_line = speed_cur ? link_up : (link_up && line_carrier);
   wire logic rx_tick  = use_line ? line_clk_tick : local_tick;
   wire logic rx_fall  = rx_tick && rx_clk;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_clk <= 1'b0;
      end else begin
         rx_clk <= rx_tick ? !rx_clk : rx_clk;
      end
   end

   // ****************************************
   // Line symbols into the receive FIFO
   // ****************************************
   phymii_rx_e    rx_state;
   phymii_rx_e    next_rx_state;
   phymii_entry_s push_entry;
   phymii_entry_s pop_entry;
   logic          fifo_in_ready;
   logic          fifo_out_valid;
   logic          push_valid;
   logic          next_crs;

   wire logic sym_take  = line_sym_valid && line_sym_ready;
   wire logic kind_idle = (line_sym.kind == PHYMII_SYM_IDLE);
   wire logic kind_end  = (line_sym.kind == PHYMII_SYM_ESD) || (line_sym.kind == PHYMII_SYM_EOF);

   always_comb begin
      next_rx_state = rx_state;
      next_crs      = crs;
      push_valid    = 1'b0;
      push_entry    = '{last: 1'b0, err: line_sym.err, nibble: line_sym.nibble};
      if (sym_take) begin
         case (line_sym.kind)
            PHYMII_SYM_SSD: begin
               if (speed_cur) begin
                  next_crs          = 1'b1;
                  next_rx_state     = PHYMII_RX_FRAME;
                  push_valid        = 1'b1;
                  push_entry.nibble = NIB_PRE;
               end
            end
            PHYMII_SYM_PRE: begin
               if (!speed_cur) begin
                  next_crs      = 1'b1;
                  next_rx_state = (rx_state == PHYMII_RX_IDLE) ? PHYMII_RX_PRE : rx_state;
               end else if (rx_state == PHYMII_RX_FRAME) begin
                  push_valid = 1'b1;
               end
            end
            PHYMII_SYM_SFD: begin
               if (rx_state != PHYMII_RX_IDLE) begin
                  next_rx_state = PHYMII_RX_FRAME;
                  push_valid    = 1'b1;
               end
            end
            PHYMII_SYM_DATA: begin
               push_valid = (rx_state == PHYMII_RX_FRAME);
            end
            PHYMII_SYM_ESD, PHYMII_SYM_EOF, PHYMII_SYM_IDLE: begin
               // Idle at 10 Mb/s only closes a frame that never began
               if (!kind_idle || speed_cur || rx_state != PHYMII_RX_FRAME) begin
                  next_crs      = 1'b0;
                  next_rx_state = PHYMII_RX_IDLE;
                  push_valid    = (rx_state == PHYMII_RX_FRAME);
                  push_entry    = '{last: 1'b1, err: 1'b0, nibble: NIB_IDLE};
               end
            end
            default: begin
               next_rx_state = rx_state;
            end
         endcase
      end
   end

   // Back-pressure: symbols stall while the FIFO cannot take an entry
   assign line_sym_ready = fifo_in_ready;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_state <= PHYMII_RX_IDLE;
         crs      <= 1'b0;
      end else begin
         rx_state <= next_rx_state;
         crs      <= next_crs;
      end
   end

   phymii_fifo #(
      .WIDTH (ENTRY_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .clock     (clock),
      .rst_n     (rst_n),
      .in_valid  (push_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (push_entry),
      .out_valid (fifo_out_valid),
      .out_ready (rx_fall),
      .out_data  (pop_entry)
   );

   // ****************************************
   // Receive outputs, moved on falling receive clock
   // ****************************************
   wire logic rx_pop = rx_fall && fifo_out_valid;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_dv <= 1'b0;
         rxd   <= NIB_IDLE;
         rx_er <= 1'b0;
      end else if (rx_pop) begin
         rx_dv <= !pop_entry.last;
         rxd   <= pop_entry.last ? NIB_IDLE : pop_entry.nibble;
         rx_er <= !pop_entry.last && pop_entry.err;
      end
   end

   // ****************************************
   // Collision
   // ****************************************
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         col <= 1'b0;
      end else begin
         col <= !full_duplex && tx_active && line_carrier;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_txclk_toggle: assert property (@(posedge clock) disable iff (!rst_n)
      local_tick |=> tx_clk != $past(tx_clk))
      else $error("transmit clock missed a toggle");

   a_tx_take_nibble: assert property (@(posedge clock) disable iff (!rst_n)
      tx_rise && tx_en |=> tx_out.valid && tx_out.en && tx_out.nibble == $past(txd))
      else $error("transmit nibble not taken");

   a_tx_idle_zero: assert property (@(posedge clock) disable iff (!rst_n)
      tx_out.valid && !tx_out.en |-> tx_out.nibble == NIB_IDLE)
      else $error("idle nibble not zero");

   a_rx_src_slow: assert property (@(posedge clock) disable iff (!rst_n)
      !speed_cur && !(link_up && line_carrier) && local_tick |=> rx_clk != $past(rx_clk))
      else $error("slow receive clock source wrong");

   a_rx_src_fast: assert property (@(posedge clock) disable iff (!rst_n)
      speed_cur && link_up && !line_clk_tick |=> rx_clk == $past(rx_clk))
      else $error("fast receive clock source wrong");

   a_rx_out_edge: assert property (@(posedge clock) disable iff (!rst_n)
      $changed(rxd) || $changed(rx_dv) |-> $past(rx_clk) && !rx_clk)
      else $error("receive output moved off the clock edge");

   a_crs_jk: assert property (@(posedge clock) disable iff (!rst_n)
      sym_take && speed_cur && line_sym.kind == PHYMII_SYM_SSD |=> crs)
      else $error("carrier sense missed start pair");

   a_crs_idle_drop: assert property (@(posedge clock) disable iff (!rst_n)
      sym_take && speed_cur && line_sym.kind == PHYMII_SYM_IDLE |=> !crs)
      else $error("carrier sense held through idle");

   a_col_half: assert property (@(posedge clock) disable iff (!rst_n)
      !full_duplex && tx_active && line_carrier |=> col)
      else $error("collision not raised");

   a_addr_zero_off: assert property (@(posedge clock) disable iff (!rst_n)
      strap_done && strap_addr == ADDR_OFF |-> !mii_oe)
      else $error("interface driven at address zero");

   a_speed_quiet: assert property (@(posedge clock) disable iff (!rst_n)
      $changed(speed_cur) |-> $past(quiet))
      else $error("speed changed inside a frame");

   a_txclk_on_tick: assert property (@(posedge clock) disable iff (!rst_n)
      $changed(tx_clk) |-> $past(local_tick))
      else $error("transmit clock moved off the divider");

   a_rxclk_on_tick: assert property (@(posedge clock) disable iff (!rst_n)
      rx_tick |=> rx_clk != $past(rx_clk))
      else $error("receive clock missed a toggle");

   a_crs_preamble: assert property (@(posedge clock) disable iff (!rst_n)
      sym_take && !speed_cur && line_sym.kind == PHYMII_SYM_PRE |=> crs)
      else $error("carrier sense missed preamble");

   a_crs_end_drop: assert property (@(posedge clock) disable iff (!rst_n)
      sym_take && kind_end |=> !crs)
      else $error("carrier sense held past end marker");

   a_dv_at_sfd: assert property (@(posedge clock) disable iff (!rst_n)
      sym_take && !speed_cur && line_sym.kind == PHYMII_SYM_SFD
         && rx_state != PHYMII_RX_IDLE |-> push_valid && !push_entry.last)
      else $error("delimiter nibble not delivered");

   a_dv_fast_pre: assert property (@(posedge clock) disable iff (!rst_n)
      sym_take && speed_cur && line_sym.kind == PHYMII_SYM_SSD
         |-> push_valid && !push_entry.last && push_entry.nibble == NIB_PRE)
      else $error("start pair not turned into preamble");

   a_rxer_flagged: assert property (@(posedge clock) disable iff (!rst_n)
      rx_pop && !pop_entry.last && pop_entry.err |=> rx_er && rx_dv)
      else $error("receive error not raised");

   a_rxer_needs_dv: assert property (@(posedge clock) disable iff (!rst_n)
      rx_er |-> rx_dv)
      else $error("receive error outside a frame");

   a_rxer_edge: assert property (@(posedge clock) disable iff (!rst_n)
      $changed(rx_er) |-> $past(rx_clk) && !rx_clk)
      else $error("receive error moved off the clock edge");

endmodule

// [design/phymii_pkg.sv]
package phymii_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLOCK_HZ  = 10_000_000;
   localparam int unsigned FAST_HZ   = 25_000_000;
   localparam int unsigned SLOW_HZ   = 2_500_000;
   localparam int unsigned HALF_FAST_RAW = CLOCK_HZ / (2 * FAST_HZ);
   localparam int unsigned HALF_SLOW_RAW = CLOCK_HZ / (2 * SLOW_HZ);
   localparam int unsigned HALF_FAST = (HALF_FAST_RAW < 1) ? 1 : HALF_FAST_RAW;
   localparam int unsigned HALF_SLOW = (HALF_SLOW_RAW < 1) ? 1 : HALF_SLOW_RAW;
   localparam int unsigned DIV_W     = 8;

   // ****************************************
   // Widths and values
   // ****************************************
   localparam int unsigned NIB_W      = 4;
   localparam int unsigned ADDR_W     = 5;
   localparam int unsigned FIFO_DEPTH = 8;
   localparam logic [3:0]  NIB_IDLE   = 4'h0;
   localparam logic [3:0]  NIB_PRE    = 4'h5;
   localparam logic [4:0]  ADDR_OFF   = 5'h00;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      PHYMII_SYM_IDLE = 3'h0,
      PHYMII_SYM_SSD  = 3'h1,
      PHYMII_SYM_ESD  = 3'h2,
      PHYMII_SYM_PRE  = 3'h3,
      PHYMII_SYM_SFD  = 3'h4,
      PHYMII_SYM_EOF  = 3'h5,
      PHYMII_SYM_DATA = 3'h6
   } phymii_sym_e;

   typedef enum logic [1:0] {
      PHYMII_RX_IDLE  = 2'b00,
      PHYMII_RX_PRE   = 2'b01,
      PHYMII_RX_FRAME = 2'b11
   } phymii_rx_e;

   typedef struct packed {
      phymii_sym_e      kind;
      logic             err;
      logic [NIB_W-1:0] nibble;
   } phymii_sym_s;

   typedef struct packed {
      logic             last;
      logic             err;
      logic [NIB_W-1:0] nibble;
   } phymii_entry_s;

   typedef struct packed {
      logic             valid;
      logic             en;
      logic [NIB_W-1:0] nibble;
   } phymii_tx_s;

   localparam int unsigned ENTRY_W = $bits(phymii_entry_s);

endpackage

// [design/phymii_fifo.sv]
module phymii_fifo
   import phymii_pkg::*;
#(
   parameter int unsigned WIDTH = ENTRY_W,
   parameter int unsigned DEPTH = FIFO_DEPTH
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);

   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [PW:0]      count;
   logic [WIDTH-1:0] head;

   wire logic        push       = in_valid && in_ready;
   wire logic        pop        = out_valid && out_ready;
   wire logic [PW:0] next_count = count + (PW+1)'(push) - (PW+1)'(pop);
   wire logic [PW-1:0] next_wr  = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
   wire logic [PW-1:0] next_rd  = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
   wire logic [PW-1:0] rd_sel   = pop ? next_rd : rd_ptr;

   // ****************************************
   // Storage, head word held in a register
   // ****************************************
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Head register lets a write into an empty FIFO show on the next cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         head <= '0;
      end else if (push && (next_count == (PW+1)'(1)) ) begin
         head <= in_data;
      end else begin
         head <= mem[rd_sel];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         count     <= '0;
         in_ready  <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         wr_ptr    <= push ? next_wr : wr_ptr;
         rd_ptr    <= pop ? next_rd : rd_ptr;
         count     <= next_count;
         in_ready  <= next_count < (PW+1)'(DEPTH);
         out_valid <= next_count != '0;
      end
   end

   assign out_data = head;

endmodule

// [tb/phymii_mac_model.sv]
// **********
// MAC side of the nibble interface
// **********
module phymii_mac_model
   import phymii_pkg::*;
(
   output logic                  tx_en,
   output logic [NIB_W-1:0]      txd,
   input  wire logic             tx_clk,
   input  wire logic             rx_clk,
   input  wire logic             rx_dv,
   input  wire logic [NIB_W-1:0] rxd,
   input  wire logic             rx_er
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [NIB_W:0]   rx_q[$];
   int               frames;
   logic             dv_last;
   // Nonzero idle nibble probes that the device ignores it
   logic [NIB_W-1:0] idle_nib;

   initial begin
      tx_en = 1'b0;
      txd = 4'h0;
      frames = 0;
      dv_last = 1'b0;
      idle_nib = 4'h0;
   end

   // Changes only just after a transmit clock rise
   task automatic send(input logic [NIB_W-1:0] nibs[$]);
      foreach (nibs[k]) begin
         @(posedge tx_clk);
         #10;
         tx_en = 1'b1;
         txd = nibs[k];
      end
      @(posedge tx_clk);
      #10;
      tx_en = 1'b0;
      txd = idle_nib;
   endtask

   // Error taken only along with valid data
   always @(posedge rx_clk) begin
      if (rx_dv === 1'b1) rx_q.push_back({rx_er, rxd});
      if (dv_last && rx_dv === 1'b0) frames++;
      dv_last = rx_dv;
   end
endmodule

// [tb/phymii_top_test.sv]
module phymii_top_test
   import phymii_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic              clock, reset_n, speed_100, link_up, full_duplex;
   logic              line_carrier, line_clk_tick, line_sym_valid, line_sym_ready;
   logic              tx_active, tx_clk, tx_en, rx_clk, rx_dv, rx_er, crs, col, mii_oe;
   logic [ADDR_W-1:0] phy_addr;
   logic [NIB_W-1:0]  txd, rxd;
   phymii_sym_s       line_sym;
   phymii_tx_s        tx_out;
   int                fails, checked, stalls, tick_cnt, tick_div, n;
   logic              tick_en, crs_seen, col_seen;
   logic [NIB_W:0]    tx_q[$];
   phymii_sym_s       syms[$];

   phymii_top i_dut (.clock(clock), .reset_n(reset_n), .speed_100(speed_100),
      .link_up(link_up), .full_duplex(full_duplex), .phy_addr(phy_addr),
      .line_carrier(line_carrier), .line_clk_tick(line_clk_tick),
      .line_sym_valid(line_sym_valid), .line_sym(line_sym), .line_sym_ready(line_sym_ready),
      .tx_out(tx_out), .tx_active(tx_active), .tx_clk(tx_clk), .tx_en(tx_en), .txd(txd),
      .rx_clk(rx_clk), .rx_dv(rx_dv), .rxd(rxd), .rx_er(rx_er), .crs(crs), .col(col),
      .mii_oe(mii_oe));

   phymii_mac_model i_mac (.tx_en(tx_en), .txd(txd), .tx_clk(tx_clk), .rx_clk(rx_clk),
      .rx_dv(rx_dv), .rxd(rxd), .rx_er(rx_er));

   // **********
   // Clock, line ticks, monitors
   // **********
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   always @(posedge clock) begin
      tick_cnt <= tick_cnt + 1;
      line_clk_tick <= #10 tick_en && (tick_cnt % tick_div == 0);
      if (tx_out.valid === 1'b1) tx_q.push_back({tx_out.en, tx_out.nibble});
      if (crs === 1'b1) crs_seen <= 1'b1;
      if (col === 1'b1) col_seen <= 1'b1;
   end

   // **********
   // Shared tasks
   // **********
   task automatic stop_test();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic cyc(input int c);
      repeat (c) @(posedge clock);
      #10;
   endtask

   task automatic add(input phymii_sym_e k, input logic [3:0] v, input logic e = 1'b0);
      syms.push_back('{kind: k, err: e, nibble: v});
   endtask

   // Holds each symbol until taken; ready is read as sampled at the edge
   task automatic push();
      int i;
      foreach (syms[k]) begin
         line_sym = syms[k];
         line_sym_valid = 1'b1;
         for (i = 0; i < 300; i++) begin
            @(posedge clock);
            if (line_sym_ready === 1'b1) break;
         end
         if (i > 0) stalls++;
         if (i == 300) begin
            fails++;
            stop_test();
         end
         #10;
      end
      line_sym_valid = 1'b0;
      syms = {};
   endtask

   // Window of 40 cycles is a whole number of periods at both rates
   task automatic rises(input logic use_rx, output int r);
      logic p, c;
      r = 0;
      p = use_rx ? rx_clk : tx_clk;
      repeat (40) begin
         @(posedge clock);
         #1;
         c = use_rx ? rx_clk : tx_clk;
         if (c && !p) r++;
         p = c;
      end
      #9;
   endtask

   task automatic rx_expect(input logic [NIB_W:0] exp[$]);
      int i;
      for (i = 0; i < 2000 && i_mac.frames == 0; i++) cyc(1);
      if (i == 2000) begin
         fails++;
         stop_test();
      end
      chk("rx count", exp.size(), i_mac.rx_q.size());
      foreach (exp[k]) chk("rx entry", exp[k], i_mac.rx_q[k]);
      i_mac.rx_q = {};
      i_mac.frames = 0;
   endtask

   task automatic do_reset(input logic [ADDR_W-1:0] a);
      phy_addr = a;
      reset_n = 1'b0;
      cyc(2);
      chk("reset outs", 0, {tx_clk, rx_clk, rx_dv, crs, col, mii_oe});
      reset_n = 1'b1;
      cyc(5);
      chk("oe strap", a != 0, mii_oe);
      $display("reset done with address %0h", a);
   endtask

   // **********
   // Scenarios
   // **********
   task automatic t_clocks();
      tick_en = 1'b0;
      cyc(8);
      rises(0, n);
      chk("tx clk fast", 20, n);
      rises(1, n);
      chk("rx clk line", 0, n);
      link_up = 1'b0;
      cyc(2);
      rises(1, n);
      chk("rx clk local", 20, n);
      speed_100 = 1'b0;
      link_up = 1'b1;
      cyc(8);
      rises(0, n);
      chk("tx clk slow", 10, n);
      rises(1, n);
      chk("rx clk idle", 10, n);
      line_carrier = 1'b1;
      cyc(2);
      rises(1, n);
      chk("rx clk carrier", 0, n);
      tick_div = 2;
      tick_en = 1'b1;
      cyc(2);
      rises(1, n);
      chk("rx clk slow line", 10, n);
      $display("clocks done");
   endtask

   task automatic t_rx10();
      add(PHYMII_SYM_PRE, 4'h5);
      add(PHYMII_SYM_PRE, 4'h5);
      push();
      cyc(2);
      chk("crs preamble", 1, crs);
      add(PHYMII_SYM_SFD, 4'hD);
      add(PHYMII_SYM_DATA, 4'h1);
      add(PHYMII_SYM_DATA, 4'h2);
      add(PHYMII_SYM_IDLE, 4'h0);
      add(PHYMII_SYM_EOF, 4'h0);
      push();
      cyc(2);
      chk("crs end", 0, crs);
      rx_expect({5'h0D, 5'h01, 5'h02});
      line_carrier = 1'b0;
      speed_100 = 1'b1;
      tick_div = 1;
      cyc(8);
      $display("rx10 done");
   endtask

   // Whole frame offered back to back so the buffer fills and refuses
   task automatic t_rx100();
      logic [NIB_W:0] e[$];
      stalls = 0;
      crs_seen = 1'b0;
      e = {5'h05};
      add(PHYMII_SYM_SSD, 4'h5);
      for (int i = 0; i < 20; i++) begin
         add(PHYMII_SYM_DATA, i[3:0], i == 5);
         e.push_back({i == 5, i[3:0]});
      end
      add(PHYMII_SYM_ESD, 4'h0);
      push();
      cyc(2);
      chk("crs jk", 1, crs_seen);
      chk("crs tr", 0, crs);
      chk("fifo refused", 1, stalls > 0);
      rx_expect(e);
      crs_seen = 1'b0;
      add(PHYMII_SYM_SSD, 4'h5);
      add(PHYMII_SYM_PRE, 4'h5);
      add(PHYMII_SYM_DATA, 4'h7);
      add(PHYMII_SYM_IDLE, 4'h0);
      push();
      cyc(2);
      chk("crs idle", 0, crs);
      chk("crs rose", 1, crs_seen);
      rx_expect({5'h05, 5'h05, 5'h07});
      $display("rx100 done");
   endtask

   task automatic t_col();
      logic [NIB_W-1:0] nb[$];
      for (int i = 0; i < 16; i++) nb.push_back(4'hA);
      for (int d = 0; d < 2; d++) begin
         full_duplex = d[0];
         col_seen = 1'b0;
         fork
            i_mac.send(nb);
            begin
               cyc(6);
               line_carrier = 1'b1;
               add(PHYMII_SYM_SSD, 4'h5);
               add(PHYMII_SYM_DATA, 4'h3);
               add(PHYMII_SYM_ESD, 4'h0);
               push();
               line_carrier = 1'b0;
            end
         join
         cyc(4);
         chk("collision", d == 0, col_seen);
         rx_expect({5'h05, 5'h03});
      end
      $display("col done");
   endtask

   task automatic t_tx();
      logic [NIB_W-1:0] nb[$];
      int               j;
      for (int i = 0; i < 26; i++) nb.push_back(i[3:0] ^ 4'h5);
      tx_q = {};
      fork
         i_mac.send(nb);
         begin
            cyc(4);
            speed_100 = 1'b0;
            rises(0, n);
            chk("speed held", 20, n);
         end
      join
      speed_100 = 1'b1;
      cyc(8);
      j = 0;
      foreach (tx_q[k]) begin
         if (tx_q[k][4]) begin
            chk("tx nibble", nb[j], tx_q[k][3:0]);
            j++;
         end else begin
            chk("tx idle", 0, tx_q[k][3:0]);
         end
      end
      chk("tx count", 26, j);
      $display("tx done");
   endtask

   initial begin
      reset_n = 1'b0;
      speed_100 = 1'b1;
      link_up = 1'b1;
      full_duplex = 1'b1;
      phy_addr = 5'h01;
      line_carrier = 1'b0;
      line_clk_tick = 1'b0;
      line_sym_valid = 1'b0;
      line_sym = '0;
      fails = 0;
      checked = 0;
      stalls = 0;
      tick_cnt = 0;
      tick_div = 1;
      tick_en = 1'b0;
      crs_seen = 1'b0;
      col_seen = 1'b0;
      #10;
      do_reset(5'h00);
      do_reset(5'h01);
      t_clocks();
      t_rx10();
      t_rx100();
      i_mac.idle_nib = 4'hF;
      t_col();
      t_tx();
      stop_test();
   end

   initial begin
      repeat (40000) @(posedge clock);
      fails++;
      stop_test();
   end
endmodule
